/* File: logic/pbu_top.sv */
// patch and breakpoint unit: apb register bank and fetch/load matching
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
//
// Overview of operation
// - instruction comparator count: bits 6:4 at control 14:12, bits 3:0 at 7:4
// - instruction count reads zero only when none are built
// - literal comparator count read-only at control bits 11:8
// - control writes ignored unless bit 1 set; bit 1 reads zero
// - global enable at control bit 0, cleared by reset
// - comparator indices 0 to icount-1 are instruction comparators
// - no more than 127 instruction comparators
// - literal comparators follow at icount..icount+lcount-1, at most 15
// - redirect-supported flag read-only at redirect base bit 29
// - base address bits 28:5 writable when redirection supported
// - without redirection the base field reads zero, writes ignored
// - redirect targets carry top bits 001, inside sram
// - instruction comparators redirect or breakpoint
// - literal comparators only redirect data reads, never breakpoint
// - comparator n redirects to base plus four times n
// - comparator acts only with its enable and global enable set
// - only reads of code region compared, address bits 1:0 ignored
module pbu_top #(
  parameter int icnt     = 6,
  parameter int lcnt     = 2,
  parameter bit remap_ok = 1'b1
) (
  // apb slave
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic        [11:0] paddr,
  input  wire logic        [31:0] pwdata,
  output logic                    pready,
  output logic             [31:0] prdata,
  output logic                    pslverr,
  // access from the fetch and load path
  input  wire pbu_pkg::pbu_fetch_t acc,
  // registered decision
  output pbu_pkg::pbu_match_t     hit,
  output logic                    unit_enabled
);
  localparam int total = icnt + lcnt;
  localparam int depth = (total > 0) ? total : 1;
  localparam int aw    = (depth > 1) ? $clog2(depth) : 1;

  initial begin
    if (icnt < 0 || icnt > pbu_pkg::max_icnt) $error("pbu_top: icnt out of range");
    if (lcnt < 0 || lcnt > pbu_pkg::max_lcnt) $error("pbu_top: lcnt out of range");
  end

  // register state
  logic        enable;
  logic [23:0] base;
  logic        rd_pend;
  logic        rd_sel;
  logic [31:0] rd_fix;

  // bus decode
  wire         setup    = psel && !penable;
  wire         access   = psel && penable;
  wire [11:0]  waddr    = paddr & pbu_pkg::addr_mask;
  wire         hit_ctrl = waddr == pbu_pkg::ctrl_addr;
  wire         hit_base = waddr == pbu_pkg::base_addr;
  wire [11:0]  comp_off = waddr - pbu_pkg::comp_addr;
  wire         hit_comp = waddr >= pbu_pkg::comp_addr
                          && 32'(comp_off[11:2]) < total;
  wire         mapped   = hit_ctrl || hit_base || hit_comp;
  // reads of the comparator store need one extra cycle for the registered memory
  wire         slow     = hit_comp && !pwrite;
  // a write lands only at the edge where the master sees pready
  wire         done     = access && pready;
  wire         wr_ok    = done && pwrite && mapped;
  wire         ctrl_wr  = wr_ok && hit_ctrl && pwdata[pbu_pkg::ctrl_key_bit];
  wire         base_wr  = wr_ok && hit_base && remap_ok;
  wire         comp_wr  = wr_ok && hit_comp;
  wire [aw-1:0] cidx    = aw'(comp_off[11:2]);

  wire [6:0]   icnt_v   = 7'(icnt);
  wire [3:0]   lcnt_v   = 4'(lcnt);
  wire [31:0]  ctrl_rd  = {17'h0, icnt_v[6:4], lcnt_v, icnt_v[3:0],
                           2'h0, 1'b0, enable};
  wire [31:0]  base_rd  = remap_ok ? {2'h0, 1'b1, base, 5'h0} : 32'h0;

  // next read data for the fast registers
  wire [31:0]  next_fix = hit_ctrl ? ctrl_rd : (hit_base ? base_rd : 32'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= 1'b0;
    end else if (ctrl_wr) begin
      enable <= pwdata[pbu_pkg::ctrl_enable_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base <= 24'h0;
    end else if (base_wr) begin
      base <= pwdata[pbu_pkg::base_msb:pbu_pkg::base_lsb];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= access && slow && !rd_pend && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_sel <= 1'b0;
      rd_fix <= 32'h0;
    end else if (setup) begin
      rd_sel <= hit_comp;
      rd_fix <= next_fix;
    end
  end

  logic [31:0]            comp_rd;
  logic [depth-1:0][31:0] words;

  pbu_comp_mem #(
    .depth (depth),
    .aw    (aw)
  ) u_mem (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (comp_wr),
    .wr_idx    (cidx),
    .wr_data   (pwdata),
    .rd_idx    (cidx),
    .rd_data   (comp_rd),
    .all_words (words)
  );

  // bus answer registered: pready pulses for the completing access cycle
  wire        next_ready = access && !pready && (!slow || rd_pend);
  wire [31:0] next_rdata = rd_sel ? comp_rd : rd_fix;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_ready;
      prdata  <= (next_ready && !pwrite) ? next_rdata : 32'h0;
      pslverr <= next_ready && !mapped;
    end
  end

  // matching: instruction comparators first, literals after them
  pbu_pkg::pbu_match_t hits [depth];

  genvar n;
  generate
    for (n = 0; n < depth; n++) begin : g_cmp
      if (n < total) begin : g_real
        pbu_matcher #(
          .index  (n),
          .is_lit (n >= icnt)
        ) u_m (
          .comp_word (words[n]),
          .unit_en   (enable),
          .remap_ok  (remap_ok),
          .base      (base),
          .acc       (acc),
          .hit       (hits[n])
        );
      end else begin : g_none
        assign hits[n] = '0;
      end
    end
  endgenerate

  // lowest index wins when several comparators match
  pbu_pkg::pbu_match_t next_hit;
  always_comb begin
    next_hit = '0;
    for (int k = depth - 1; k >= 0; k--) begin
      if (hits[k].redirect || hits[k].brk_lo || hits[k].brk_hi) begin
        next_hit = hits[k];
      end
    end
    if (!acc.valid || acc.addr[31:30] != 2'h0) begin
      next_hit = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit          <= '0;
      unit_enabled <= 1'b0;
    end else begin
      hit          <= next_hit;
      unit_enabled <= enable;
    end
  end
endmodule

/* File: shared/pbu_pkg.sv */
// constants and types shared by the patch and breakpoint unit
package pbu_pkg;
  // register byte addresses
  localparam logic [11:0] ctrl_addr    = 12'h000;
  localparam logic [11:0] base_addr    = 12'h004;
  localparam logic [11:0] comp_addr    = 12'h008;
  localparam logic [11:0] addr_mask    = 12'hffc;
  // control register fields
  localparam int ctrl_enable_bit  = 0;
  localparam int ctrl_key_bit     = 1;
  localparam int ctrl_icnt_lo_lsb = 4;
  localparam int ctrl_lcnt_lsb    = 8;
  localparam int ctrl_icnt_hi_lsb = 12;
  // redirect base register fields
  localparam int base_lsb         = 5;
  localparam int base_msb         = 28;
  localparam int base_flag_bit    = 29;
  localparam logic [2:0] sram_top = 3'h1;
  // comparator register fields
  localparam int comp_en_bit      = 0;
  localparam int comp_lsb         = 2;
  localparam int comp_msb         = 28;
  localparam int comp_mode_lsb    = 30;
  localparam logic [1:0] mode_redirect = 2'h0;
  localparam int max_icnt         = 127;
  localparam int max_lcnt         = 15;
  localparam logic [2:0] code_top = 3'h0;

  typedef struct packed {
    logic        valid;
    logic        is_data;
    logic [31:0] addr;
  } pbu_fetch_t;

  typedef struct packed {
    logic        redirect;
    logic        brk_lo;
    logic        brk_hi;
    logic [31:0] target;
  } pbu_match_t;
endpackage

/* File: logic/pbu_comp_mem.sv */
// storage for the comparator registers with registered read data
`timescale 1ns/1ps
module pbu_comp_mem #(
  parameter int depth = 8,
  parameter int aw    = 3
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // write port
  input  wire logic              wr_en,
  input  wire logic [aw-1:0]     wr_idx,
  input  wire logic [31:0]       wr_data,
  // read port
  input  wire logic [aw-1:0]     rd_idx,
  output logic      [31:0]       rd_data,
  // flat view for the matchers
  output logic [depth-1:0][31:0] all_words
);
  logic [depth-1:0][31:0] mem;

  initial begin
    if (depth < 1 || (1 << aw) < depth) $error("pbu_comp_mem: bad depth or aw");
  end

  genvar i;
  generate
    for (i = 0; i < depth; i++) begin : g_word
      // the whole word clears at reset: enable, address and mode alike
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem[i] <= 32'h0;
        end else if (wr_en && wr_idx == aw'(i)) begin
          mem[i] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= (32'(rd_idx) < depth) ? mem[rd_idx] : 32'h0;
    end
  end

  assign all_words = mem;
endmodule

/* File: logic/pbu_matcher.sv */
// one address comparator: match, redirect or breakpoint decision
`timescale 1ns/1ps
module pbu_matcher #(
  parameter int index     = 0,
  parameter bit is_lit    = 1'b0
) (
  // comparator setting and global state
  input  wire logic              [31:0] comp_word,
  input  wire logic                     unit_en,
  input  wire logic                     remap_ok,
  input  wire logic              [23:0] base,
  // access under test
  input  wire pbu_pkg::pbu_fetch_t      acc,
  // decision
  output pbu_pkg::pbu_match_t           hit
);
  wire in_code = acc.valid && acc.addr[31:30] == 2'h0;
  wire kind_ok = is_lit ? acc.is_data : !acc.is_data;
  wire on      = comp_word[pbu_pkg::comp_en_bit] && unit_en;
  // bits 1:0 ignored, word granularity
  wire same    = acc.addr[28:2] == comp_word[pbu_pkg::comp_msb:pbu_pkg::comp_lsb];
  wire match   = on && in_code && kind_ok && same && acc.addr[31:29] == pbu_pkg::code_top;
  wire [1:0] mode = is_lit ? pbu_pkg::mode_redirect
                           : comp_word[pbu_pkg::comp_mode_lsb +: 2];
  wire [31:0] tgt = {pbu_pkg::sram_top, base, 5'h0} + 32'(index * 4);

  assign hit.redirect = match && remap_ok && mode == pbu_pkg::mode_redirect;
  assign hit.brk_lo   = match && !is_lit && mode[0];
  assign hit.brk_hi   = match && !is_lit && mode[1];
  assign hit.target   = tgt;
endmodule

/* File: verif/pbu_asserts.sv */
// port checker for the patch and breakpoint unit
`timescale 1ns/1ps
module pbu_asserts #(
  parameter int icnt     = 6,
  parameter int lcnt     = 2,
  parameter bit remap_ok = 1'b1
) (
  // apb
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic         [11:0] paddr,
  input wire logic         [31:0] pwdata,
  input wire logic                pready,
  input wire logic         [31:0] prdata,
  input wire logic                pslverr,
  // matching
  input wire pbu_pkg::pbu_fetch_t acc,
  input wire pbu_pkg::pbu_match_t hit,
  input wire logic                unit_enabled
);
  localparam logic [6:0] ic = 7'(icnt);
  localparam logic [3:0] lc = 4'(lcnt);
  wire done   = psel && penable && pready;
  wire ctl_wr = done && pwrite && paddr == pbu_pkg::ctrl_addr;
  wire ctl_rd = done && !pwrite && paddr == pbu_pkg::ctrl_addr;
  wire bas_rd = done && !pwrite && paddr == pbu_pkg::base_addr;
  wire any    = hit.redirect || hit.brk_lo || hit.brk_hi;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_key_guard: assert property (ctl_wr && !pwdata[1] |=> $stable(unit_enabled)[*2])
    else $error("control write without key moved the enable");
  chk_enable_set: assert property (ctl_wr && pwdata[1] |->
    ##2 unit_enabled == $past(pwdata[0], 2))
    else $error("keyed control write did not set the enable");
  chk_ctrl_read: assert property (ctl_rd |->
    prdata == {17'h0, ic[6:4], lc, ic[3:0], 3'h0, unit_enabled})
    else $error("control read value wrong");
  chk_base_flag: assert property (bas_rd |->
    prdata == (remap_ok ? {3'h1, prdata[28:5], 5'h0} : 32'h0))
    else $error("redirect base read value wrong");
  chk_target_top: assert property (hit.redirect |->
    hit.target[31:29] == pbu_pkg::sram_top && hit.target[1:0] == 2'h0)
    else $error("redirect target outside sram");
  chk_global_off: assert property (!unit_enabled ##1 !unit_enabled ##1 !unit_enabled
    |-> !$past(any))
    else $error("hit while unit disabled");
  chk_code_only: assert property (acc.valid && acc.addr[31:29] != pbu_pkg::code_top
    |=> !any)
    else $error("hit outside code region");
  chk_idle_quiet: assert property (!acc.valid |=> !any)
    else $error("hit without an access");
  cover property (ctl_wr && pwdata[1]);
  cover property (hit.redirect);
  cover property (hit.brk_lo && hit.brk_hi);
endmodule

bind pbu_top pbu_asserts #(.icnt(icnt), .lcnt(lcnt), .remap_ok(remap_ok)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .acc(acc), .hit(hit), .unit_enabled(unit_enabled));

/* File: verif/pbu_fetch_model.sv */
// behavioural fetch and literal load path facing the unit
`timescale 1ns/1ps
module pbu_fetch_model (
  // clock
  input wire logic            pclk,
  // access to the unit
  output pbu_pkg::pbu_fetch_t acc
);
  initial acc = '0;
  // reads only: writes never reach the comparators
  task automatic issue(input logic d, input logic [31:0] a);
    @(posedge pclk);
    acc <= '{valid: 1'b1, is_data: d, addr: a};
    @(posedge pclk);
    // scrambled once released so a stale address cannot match by luck
    acc <= '{valid: 1'b0, is_data: ~d, addr: ~a};
  endtask
endmodule

/* File: verif/tb_pbu_top.sv */
// self-checking bench for the patch and breakpoint unit
`timescale 1ns/1ps
module tb_pbu_top;
  localparam int ic = 18;
  localparam int lc = 15;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic         [11:0] paddr = 12'h000;
  logic         [31:0] pwdata = 32'h0;
  logic         [31:0] rd;
  logic         [31:0] rd_nr;
  logic         [31:0] prdata;
  logic         [31:0] prdata_nr;
  logic                pready;
  logic                pslverr;
  logic                err;
  logic                unit_enabled;
  pbu_pkg::pbu_fetch_t acc;
  pbu_pkg::pbu_match_t hit;
  int                  mismatches = 0;
  int                  cmp_count = 0;
  logic         [11:0] ca [8] = '{12'h008, 12'h00c, 12'h010, 12'h014,
                                  12'h04c, 12'h050, 12'h054, 12'h088};
  logic         [31:0] cw [8] = '{32'h0000_0101, 32'hc000_0301, 32'h4000_0401, 32'h8000_0701,
                                  32'h0000_0501, 32'h0000_0201, 32'h0000_0800, 32'h0000_0601};
  always #50 pclk = ~pclk;
  pbu_top #(.icnt(ic), .lcnt(lc), .remap_ok(1'b1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .acc(acc), .hit(hit), .unit_enabled(unit_enabled));
  // same bus, no redirect support: same timing, only read data looked at
  pbu_top #(.icnt(ic), .lcnt(lc), .remap_ok(1'b0)) dut_nr (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdata_nr), .pslverr(),
    .acc(acc), .hit(), .unit_enabled());
  pbu_fetch_model pm (.pclk(pclk), .acc(acc));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    rd_nr = prdata_nr;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t read %h want %h", $time, g, e);
    end
  endtask
  // target only matters on a redirect
  task automatic chk_hit(input logic d, input logic [31:0] a, input pbu_pkg::pbu_match_t e);
    pm.issue(d, a);
    #1;
    cmp_count++;
    if ({hit.redirect, hit.brk_lo, hit.brk_hi} !== {e.redirect, e.brk_lo, e.brk_hi} ||
        (e.redirect && hit.target !== e.target)) begin
      mismatches++;
      $display("BAD %0t access %h gave %h", $time, a, hit);
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, pbu_pkg::ctrl_addr, 32'h0);
    chk32(rd, 32'h0000_1f20);
    chk32({31'h0, unit_enabled}, 32'h0);
    apb(1, pbu_pkg::ctrl_addr, 32'hffff_fffd);
    apb(0, pbu_pkg::ctrl_addr, 32'h0);
    chk32(rd, 32'h0000_1f20);
    apb(1, pbu_pkg::ctrl_addr, 32'hffff_ffff);
    apb(0, pbu_pkg::ctrl_addr, 32'h0);
    chk32(rd, 32'h0000_1f21);
    chk32({31'h0, unit_enabled}, 32'h1);
    apb(0, pbu_pkg::base_addr, 32'h0);
    chk32(rd, 32'h2000_0000);
    chk32(rd_nr, 32'h0);
    apb(1, pbu_pkg::base_addr, 32'hffff_ffff);
    apb(0, pbu_pkg::base_addr, 32'h0);
    chk32(rd, 32'h3fff_ffe0);
    chk32(rd_nr, 32'h0);
    apb(1, pbu_pkg::base_addr, 32'h0000_1000);
    foreach (ca[i]) apb(1, ca[i], cw[i]);
    apb(0, 12'h050, 32'h0);
    chk32(rd, 32'h0000_0201);
    chk32({31'h0, err}, 32'h0);
    apb(0, 12'h08c, 32'h0);
    chk32({31'h0, err}, 32'h1);
    chk_hit(0, 32'h0000_0102, '{1'b1, 1'b0, 1'b0, 32'h2000_1000});
    chk_hit(0, 32'h0000_0300, '{1'b0, 1'b1, 1'b1, 32'h0});
    chk_hit(0, 32'h0000_0400, '{1'b0, 1'b1, 1'b0, 32'h0});
    chk_hit(0, 32'h0000_0702, '{1'b0, 1'b0, 1'b1, 32'h0});
    chk_hit(1, 32'h0000_0800, '{1'b0, 1'b0, 1'b0, 32'h0});
    chk_hit(0, 32'h0000_0500, '{1'b1, 1'b0, 1'b0, 32'h2000_1044});
    chk_hit(1, 32'h0000_0200, '{1'b1, 1'b0, 1'b0, 32'h2000_1048});
    chk_hit(1, 32'h0000_0603, '{1'b1, 1'b0, 1'b0, 32'h2000_1080});
    chk_hit(0, 32'h2000_0100, '{1'b0, 1'b0, 1'b0, 32'h0});
    chk_hit(0, 32'h0000_0104, '{1'b0, 1'b0, 1'b0, 32'h0});
    apb(1, pbu_pkg::ctrl_addr, 32'h0000_0002);
    chk_hit(0, 32'h0000_0100, '{1'b0, 1'b0, 1'b0, 32'h0});
    final_report();
  end
  initial begin
    #5000000;
    mismatches++;
    final_report();
  end
endmodule
